// *** verilog/ltc_pkg.sv ***
package ltc_pkg;
   // register offsets
   localparam logic [7:0] LTC_ADDR_IMP   = 8'h03;
   localparam logic [7:0] LTC_ADDR_TRANSMIT_CONFIG_ZERO  = 8'h05;
   localparam logic [7:0] LTC_ADDR_TRANSMIT_CONFIG_ONE  = 8'h06;
   localparam logic [7:0] LTC_ADDR_SCALE = 8'h07;
   localparam logic [7:0] LTC_ADDR_CTL   = 8'h08;
   localparam logic [7:0] LTC_ADDR_STAT  = 8'h09;
   // field positions
   localparam int LTC_RTERM_LSB = 0;
   localparam int LTC_TTERM_LSB = 3;
   localparam int LTC_TOFF_BIT  = 4;
   localparam int LTC_THZ_BIT   = 0;
   localparam int LTC_SRST_BIT  = 0;
   // reset values and build-out default scales
   localparam logic [2:0] LTC_TERM_RST  = 3'h0;
   localparam logic [3:0] LTC_PULS_RST  = 4'h0;
   localparam logic [5:0] LTC_SCAL_RST  = 6'h36;
   localparam logic [5:0] LTC_SCAL_D75  = 6'h11;
   localparam logic [5:0] LTC_SCAL_D150 = 6'h08;
   localparam logic [5:0] LTC_SCAL_D225 = 6'h04;
   // pulse template codes
   localparam logic [3:0] LTC_P_E175  = 4'h0;
   localparam logic [3:0] LTC_P_E1120 = 4'h1;
   localparam logic [3:0] LTC_P_J1    = 4'h7;
   localparam logic [3:0] LTC_P_D75   = 4'h9;
   localparam logic [3:0] LTC_P_D150  = 4'ha;
   localparam logic [3:0] LTC_P_D225  = 4'hb;
   // internal impedance codes
   localparam logic [1:0] LTC_IMP_E175  = 2'h0;
   localparam logic [1:0] LTC_IMP_E1120 = 2'h1;
   localparam logic [1:0] LTC_IMP_T1    = 2'h2;
   localparam logic [1:0] LTC_IMP_J1    = 2'h3;
   // strap settle: two sync stages plus one
   localparam logic [1:0] LTC_START_CNT = 2'h3;
   // attenuated build-out templates, element = ui*16 + sample
   localparam logic [0:63][7:0] LTC_WAVE_D75 = {
      128'h0002_0913_1d25_2b31_363a_3930_2820_1a17,
      128'h1412_100e_0c0b_0a09_0807_0605_0404_0303,
      128'h0202_0202_0201_0101_0101_0101_0000_0000,
      128'h0000_0000_0000_0000_0000_0000_0000_0000};
   localparam logic [0:63][7:0] LTC_WAVE_D150 = {
      128'h0000_0001_0408_0e14_1b22_2a30_3537_3837,
      128'h3533_302d_2a27_2421_1e1c_1a17_1514_1210,
      128'h0f0d_0c0b_0a09_0807_0606_0505_0404_0303,
      128'h0302_0202_0201_0101_0101_0101_0100_0000};
   localparam logic [0:63][7:0] LTC_WAVE_D225 = {
      128'h0000_0000_0103_070b_0f15_191c_2023_272a,
      128'h2c2e_3031_3232_3231_302e_2c29_2724_2220,
      128'h1e1c_1a18_1715_1413_1110_0f0e_0d0c_0a09,
      128'h0807_0605_0504_0403_0302_0202_0101_0101};

   typedef struct packed {
      logic       ext;
      logic [1:0] imp;
   } ltc_term_t;

   typedef enum logic [1:0] {
      LTC_ST_START = 2'b00,
      LTC_ST_RUN   = 2'b01
   } ltc_state_t;
endpackage

// *** verilog/ltc_line_ctl.sv ***
`timescale 1ns/1ps
module ltc_line_ctl
   import ltc_pkg::*;
(
   // clock and reset
   input  wire logic       clock_in,
   input  wire logic       rstn_in,
   // register port
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   // strap pins
   input  wire logic       hw_mode_in,
   input  wire logic       term_strap_in,
   input  wire logic       tx_float_ctl_in,
   input  wire logic       pattern_strap_hi_in,
   input  wire logic       pattern_strap_lo_in,
   input  wire logic [3:0] pulse_template_sel_in,
   // transmit side status and data
   input  wire logic       mclk_lost_in,
   input  wire logic       transmit_clock_lost_in,
   input  wire logic       remote_loop_in,
   input  wire logic       pattern_on_mclk_in,
   input  wire logic       tx_pos_in,
   input  wire logic       tx_neg_in,
   input  wire logic [5:0] wave_idx_in,
   // line and analog control
   output logic            tx_line_pos_out,
   output logic            tx_line_neg_out,
   output logic            tx_line_oe_out,
   output logic            tx_power_down_out,
   output ltc_term_t       tx_term_out,
   output ltc_term_t       rx_term_out,
   output logic      [3:0] pulse_template_sel_out,
   output logic      [5:0] amplitude_scale_out,
   output logic      [6:0] wave_code_out
);

////////////////////////////////////////////////////////////////////////////////
// strap synchronisers

   logic [8:0] strap_s1_r, strap_s2_r;
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         strap_s1_r <= 9'h000;
         strap_s2_r <= 9'h000;
      end else begin
         strap_s1_r <= {hw_mode_in, term_strap_in, tx_float_ctl_in, pattern_strap_hi_in,
                        pattern_strap_lo_in, pulse_template_sel_in};
         strap_s2_r <= strap_s1_r;
      end
   end

   logic       hw_sync, term_sync, float_sync, phi_sync, plo_sync;
   logic [3:0] puls_sync;
   assign {hw_sync, term_sync, float_sync, phi_sync, plo_sync, puls_sync} = strap_s2_r;

////////////////////////////////////////////////////////////////////////////////
// registers and start-up

   ltc_state_t st_r, st_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic       hw_r, hw_nxt;
   logic [2:0] rterm_r, rterm_nxt, tterm_r, tterm_nxt;
   logic [3:0] puls_r, puls_nxt;
   logic [5:0] scal_r, scal_nxt;
   logic       toff_r, toff_nxt, thz_r, thz_nxt;
   logic       srst;

   assign srst = wr_in && addr_in == LTC_ADDR_CTL && wdata_in[LTC_SRST_BIT];

   always_comb begin
      st_nxt    = st_r;
      cnt_nxt   = cnt_r;
      hw_nxt    = hw_r;
      rterm_nxt = rterm_r;
      tterm_nxt = tterm_r;
      puls_nxt  = puls_r;
      scal_nxt  = scal_r;
      toff_nxt  = toff_r;
      thz_nxt   = thz_r;
      case (st_r)
         LTC_ST_START: begin
            // wait for straps to pass the synchroniser before trusting them
            cnt_nxt = cnt_r + 2'h1;
            if (cnt_r == LTC_START_CNT - 2'h1) begin
               hw_nxt = hw_sync;
               st_nxt = LTC_ST_RUN;
            end
         end
         LTC_ST_RUN: begin
            if (wr_in) begin
               case (addr_in)
                  LTC_ADDR_IMP: begin
                     rterm_nxt = wdata_in[LTC_RTERM_LSB +: 3];
                     tterm_nxt = wdata_in[LTC_TTERM_LSB +: 3];
                  end
                  LTC_ADDR_TRANSMIT_CONFIG_ZERO: begin
                     toff_nxt = wdata_in[LTC_TOFF_BIT];
                     puls_nxt = wdata_in[3:0];
                     // picking an attenuated build-out loads its default scale
                     case (wdata_in[3:0])
                        LTC_P_D75:  scal_nxt = LTC_SCAL_D75;
                        LTC_P_D150: scal_nxt = LTC_SCAL_D150;
                        LTC_P_D225: scal_nxt = LTC_SCAL_D225;
                        default:    scal_nxt = scal_r;
                     endcase
                  end
                  LTC_ADDR_TRANSMIT_CONFIG_ONE:  thz_nxt  = wdata_in[LTC_THZ_BIT];
                  LTC_ADDR_SCALE: scal_nxt = wdata_in[5:0];
                  default: ;
               endcase
            end
            if (srst) begin
               // soft reset clears the registers and reruns start-up (strap synchronisers keep their state), pins float meanwhile
               st_nxt    = LTC_ST_START;
               cnt_nxt   = 2'h0;
               rterm_nxt = LTC_TERM_RST;
               tterm_nxt = LTC_TERM_RST;
               puls_nxt  = LTC_PULS_RST;
               scal_nxt  = LTC_SCAL_RST;
               toff_nxt  = 1'b0;
               thz_nxt   = 1'b0;
            end
         end
         default: st_nxt = LTC_ST_START;
      endcase
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_r    <= LTC_ST_START;
         cnt_r   <= 2'h0;
         hw_r    <= 1'b0;
         rterm_r <= LTC_TERM_RST;
         tterm_r <= LTC_TERM_RST;
         puls_r  <= LTC_PULS_RST;
         scal_r  <= LTC_SCAL_RST;
         toff_r  <= 1'b0;
         thz_r   <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         cnt_r   <= cnt_nxt;
         hw_r    <= hw_nxt;
         rterm_r <= rterm_nxt;
         tterm_r <= tterm_nxt;
         puls_r  <= puls_nxt;
         scal_r  <= scal_nxt;
         toff_r  <= toff_nxt;
         thz_r   <= thz_nxt;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// effective controls

   logic       run, pd, float_req, hiz, t1j1, ext_refused;
   logic [3:0] puls_eff;
   logic [1:0] strap_imp;
   ltc_term_t  tx_term, rx_term;

   always_comb begin
      case (puls_sync)
         LTC_P_E175:  strap_imp = LTC_IMP_E175;
         LTC_P_E1120: strap_imp = LTC_IMP_E1120;
         LTC_P_J1:    strap_imp = LTC_IMP_J1;
         default:     strap_imp = LTC_IMP_T1;
      endcase
   end

   assign run      = st_r == LTC_ST_RUN;
   assign puls_eff = hw_r ? puls_sync : puls_r;
   assign pd       = hw_r ? (phi_sync && plo_sync) : toff_r;
   assign float_req = hw_r ? float_sync : thz_r;
   // tx path stays clocked while floating, only the drivers let go
   assign hiz = !run || float_req || pd || mclk_lost_in ||
                (transmit_clock_lost_in && !remote_loop_in && !pattern_on_mclk_in);
   // in register mode T1/J1 tx has no external option: keep internal matching
   assign t1j1        = tterm_r[1:0] == LTC_IMP_T1 || tterm_r[1:0] == LTC_IMP_J1;
   assign ext_refused = !hw_r && tterm_r[2] && t1j1;

   always_comb begin
      if (hw_r) begin
         tx_term.ext = !term_sync;
         tx_term.imp = strap_imp;
         rx_term     = tx_term;
      end else begin
         tx_term.ext = tterm_r[2] && !t1j1;
         tx_term.imp = tterm_r[1:0];
         rx_term.ext = rterm_r[2];
         rx_term.imp = rterm_r[1:0];
      end
   end

   logic [6:0] wave;
   always_comb begin
      case (puls_eff)
         LTC_P_D75:  wave = LTC_WAVE_D75[wave_idx_in][6:0];
         LTC_P_D150: wave = LTC_WAVE_D150[wave_idx_in][6:0];
         LTC_P_D225: wave = LTC_WAVE_D225[wave_idx_in][6:0];
         default:    wave = 7'h00;
      endcase
   end

////////////////////////////////////////////////////////////////////////////////
// output and read-back registers

   logic [7:0] rd_nxt;
   always_comb begin
      rd_nxt = 8'h00;
      if (rd_in) begin
         case (addr_in)
            LTC_ADDR_IMP:   rd_nxt = {2'h0, tterm_r, rterm_r};
            LTC_ADDR_TRANSMIT_CONFIG_ZERO:  rd_nxt = {3'h0, toff_r, puls_r};
            LTC_ADDR_TRANSMIT_CONFIG_ONE:  rd_nxt = {7'h00, thz_r};
            LTC_ADDR_SCALE: rd_nxt = {2'h0, scal_r};
            LTC_ADDR_STAT:  rd_nxt = {3'h0, ext_refused, run, hiz, pd, hw_r};
            default:        rd_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_out              <= 8'h00;
         tx_line_pos_out        <= 1'b0;
         tx_line_neg_out        <= 1'b0;
         tx_line_oe_out         <= 1'b0;
         tx_power_down_out      <= 1'b0;
         tx_term_out            <= '0;
         rx_term_out            <= '0;
         pulse_template_sel_out <= LTC_PULS_RST;
         amplitude_scale_out    <= LTC_SCAL_RST;
         wave_code_out          <= 7'h00;
      end else begin
         rdata_out              <= rd_nxt;
         tx_line_pos_out        <= tx_pos_in && !hiz;
         tx_line_neg_out        <= tx_neg_in && !hiz;
         tx_line_oe_out         <= !hiz;
         tx_power_down_out      <= pd;
         tx_term_out            <= tx_term;
         rx_term_out            <= rx_term;
         pulse_template_sel_out <= puls_eff;
         amplitude_scale_out    <= scal_r;
         wave_code_out          <= wave;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// checks

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);

   chk_float_bit_hiz: assert property (run && !hw_r && thz_r |=> !tx_line_oe_out)
      else $error("float bit did not release tx pins");
   chk_strap_float: assert property (run && hw_r && float_sync |=> !tx_line_oe_out)
      else $error("float strap did not release tx pins");
   chk_clk_loss: assert property (mclk_lost_in || (transmit_clock_lost_in && !remote_loop_in
                                  && !pattern_on_mclk_in) |=> !tx_line_oe_out)
      else $error("clock loss left tx pins driven");
   chk_soft_reset: assert property (srst && run |=> !run ##1 !tx_line_oe_out [*3])
      else $error("soft reset did not float tx pins");
   chk_toff_pd: assert property (run && !hw_r && toff_r |=>
                                 tx_power_down_out && !tx_line_oe_out)
      else $error("power-off bit ineffective");
   chk_strap_pd: assert property (hw_r && run |=>
                                  tx_power_down_out == $past(phi_sync && plo_sync))
      else $error("pattern strap power-down wrong");
   chk_hw_term: assert property (hw_r |=> tx_term_out.ext == $past(!term_sync) &&
                                 rx_term_out == tx_term_out)
      else $error("term strap matching wrong");
   chk_tx_term: assert property (!hw_r && !tterm_r[2] |=>
                                 !tx_term_out.ext && tx_term_out.imp == $past(tterm_r[1:0]))
      else $error("tx internal matching wrong");
   chk_t1_no_ext: assert property (!hw_r && t1j1 |=> !tx_term_out.ext)
      else $error("external tx matching in T1/J1");
   chk_rx_term: assert property (!hw_r |=> rx_term_out.ext == $past(rterm_r[2]))
      else $error("rx matching select wrong");
   chk_d75_scale: assert property (run && wr_in && addr_in == LTC_ADDR_TRANSMIT_CONFIG_ZERO &&
                                   wdata_in[3:0] == LTC_P_D75 && !srst |=>
                                   scal_r == 6'h11)
      else $error("-7.5 dB default scale wrong");
   chk_d225_wave: assert property (puls_eff == LTC_P_D225 && wave_idx_in == 6'h14 |=>
                                   wave_code_out == 7'h32)
      else $error("-22.5 dB sample wrong");

   cov_float:   cover property (run && !hw_r ##1 thz_r ##1 !tx_line_oe_out);
   cov_hw_pd:   cover property (hw_r && phi_sync && plo_sync ##1 tx_power_down_out);
   cov_d150:    cover property (puls_eff == LTC_P_D150 && wave_idx_in == 6'h3f);
   cov_refused: cover property (ext_refused);
endmodule

// *** sim/ltc_cable_model.sv ***
`timescale 1ns/1ps
module ltc_cable_model (
   // clock
   input  wire logic clock_in,
   // driver pins
   input  wire logic tx_line_pos_in,
   input  wire logic tx_line_neg_in,
   input  wire logic tx_line_oe_in,
   // levels seen on the cable
   output logic      line_pos_out,
   output logic      line_neg_out
);
   logic toggle_r = 1'b0;
   ////////////////////////////////////////////////////////////////////////////////
   // a floated pair holds no level: show a changing pattern so stale data never passes
   always @(posedge clock_in) toggle_r <= ~toggle_r;
   assign line_pos_out = tx_line_oe_in ? tx_line_pos_in : toggle_r;
   assign line_neg_out = tx_line_oe_in ? tx_line_neg_in : ~toggle_r;
endmodule

// *** sim/line_driver_termination_control_test.sv ***
`timescale 1ns/1ps
module line_driver_termination_control_test;
   import ltc_pkg::*;
   logic       clock_in = 1'b0;
   logic       rstn_in = 1'b0;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
   logic       wr_in = 1'b0, rd_in = 1'b0, hw_mode_in = 1'b0, term_strap_in = 1'b1;
   logic       tx_float_ctl_in = 1'b0, pattern_strap_hi_in = 1'b0, pattern_strap_lo_in = 1'b0;
   logic [3:0] pulse_template_sel_in = 4'h0, pulse_template_sel_out;
   logic       mclk_lost_in = 1'b0, transmit_clock_lost_in = 1'b0, remote_loop_in = 1'b0;
   logic       pattern_on_mclk_in = 1'b0, tx_pos_in = 1'b0, tx_neg_in = 1'b1;
   logic [5:0] wave_idx_in = 6'h00, amplitude_scale_out;
   logic       tx_line_pos_out, tx_line_neg_out, tx_line_oe_out, tx_power_down_out;
   ltc_term_t  tx_term_out, rx_term_out;
   logic [6:0] wave_code_out;
   logic       line_pos, line_neg, rd_d = 1'b0, pos_d = 1'b0, neg_d = 1'b0;
   logic [7:0] exp_q[$];
   int         errors = 0, total_checks = 0, seed = 98979;
   // spot samples {template, index, code} of the attenuated build-outs
   logic [19:0] spots [9] = '{20'h9093a, 20'h91014, 20'h92002, 20'ha0f37, 20'ha1035,
                               20'ha3003, 20'hb0000, 20'hb1532, 20'hb3f01};
   // strap cases {term, template, expected impedance}
   logic [11:0] hwc [5] = '{12'h100, 12'h111, 12'h132, 12'h173, 12'h1a2};
   logic [4:0]  lossc [4] = '{5'b10000, 5'b01000, 5'b01101, 5'b01011};

   ltc_line_ctl DUT (.clock_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .hw_mode_in, .term_strap_in, .tx_float_ctl_in, .pattern_strap_hi_in, .pattern_strap_lo_in,
      .pulse_template_sel_in, .mclk_lost_in, .transmit_clock_lost_in, .remote_loop_in,
      .pattern_on_mclk_in, .tx_pos_in, .tx_neg_in, .wave_idx_in, .tx_line_pos_out,
      .tx_line_neg_out, .tx_line_oe_out, .tx_power_down_out, .tx_term_out, .rx_term_out,
      .pulse_template_sel_out, .amplitude_scale_out, .wave_code_out);
   ltc_cable_model cable (.clock_in, .tx_line_pos_in(tx_line_pos_out),
      .tx_line_neg_in(tx_line_neg_out), .tx_line_oe_in(tx_line_oe_out),
      .line_pos_out(line_pos), .line_neg_out(line_neg));

   always #10 clock_in = ~clock_in;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally(input logic [7:0] g, input logic [7:0] e, input string what);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, g, e);
      end
   endtask
   task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
      tally(g, e, "read data");
   endtask
   task automatic cmp_out(input logic [7:0] g, input logic [7:0] e);
      tally(g, e, "output");
   endtask
   // read data stands only in the cycle after the strobe
   always @(posedge clock_in) begin
      if (rd_d) cmp_rd(rdata_out, exp_q.pop_front());
      // a driven pair must carry the data level launched one edge earlier
      if (tx_line_oe_out) cmp_out({6'h0, line_pos, line_neg}, {6'h0, pos_d, neg_d});
      rd_d <= rd_in;
      pos_d <= tx_pos_in;
      neg_d <= tx_neg_in;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      exp_q.push_back(e);
      @(posedge clock_in);
      rd_in <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) begin
         @(posedge clock_in);
         tx_pos_in <= 1'($random(seed));
         tx_neg_in <= ~tx_pos_in;
      end
      #1;
   endtask
   task automatic do_reset(input logic hw);
      @(posedge clock_in);
      rstn_in <= 1'b0;
      hw_mode_in <= hw;
      repeat (3) @(posedge clock_in);
      rstn_in <= 1'b1;
      settle(2);
      cmp_out(tx_line_oe_out, 8'h00);
      settle(6);
   endtask
   task automatic test_done;
      $display("errors=%0d total_checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #400us;
      errors++;
      test_done();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset(1'b0);
      rd(LTC_ADDR_IMP, 8'h00);
      rd(LTC_ADDR_TRANSMIT_CONFIG_ZERO, 8'h00);
      rd(LTC_ADDR_TRANSMIT_CONFIG_ONE, 8'h00);
      rd(LTC_ADDR_SCALE, 8'h36);
      rd(8'h20, 8'h00);
      cmp_out(tx_line_oe_out, 8'h01);
      for (int i = 0; i < 64; i++) begin
         wr(LTC_ADDR_IMP, 8'(i));
         settle(3);
         cmp_out({5'h0, rx_term_out}, {5'h0, 3'(i)});
         cmp_out({5'h0, tx_term_out}, {5'h0, i[5] & ~i[4], i[4:3]});
         rd(LTC_ADDR_STAT, {3'h0, i[5] & i[4], 4'h8});
      end
      wr(LTC_ADDR_IMP, 8'h00);
      wr(LTC_ADDR_TRANSMIT_CONFIG_ONE, 8'h01);
      settle(3);
      cmp_out(tx_line_oe_out, 8'h00);
      cmp_out(tx_line_pos_out, 8'h00);
      cmp_out(tx_power_down_out, 8'h00);
      rd(LTC_ADDR_STAT, 8'h0c);
      wr(LTC_ADDR_TRANSMIT_CONFIG_ONE, 8'h00);
      settle(4);
      foreach (lossc[k]) begin
         @(posedge clock_in);
         {mclk_lost_in, transmit_clock_lost_in, remote_loop_in, pattern_on_mclk_in} <= lossc[k][4:1];
         settle(2);
         cmp_out(tx_line_oe_out, {7'h0, lossc[k][0]});
         @(posedge clock_in);
         {mclk_lost_in, transmit_clock_lost_in, remote_loop_in, pattern_on_mclk_in} <= 4'h0;
         settle(5);
      end
      for (int t = 0; t < 12; t++) begin
         wr(LTC_ADDR_TRANSMIT_CONFIG_ZERO, 8'(t));
         settle(3);
         cmp_out({4'h0, pulse_template_sel_out}, 8'(t));
         if (t == 9) cmp_out({2'h0, amplitude_scale_out}, 8'h11);
         if (t == 10) cmp_out({2'h0, amplitude_scale_out}, 8'h08);
         if (t == 11) cmp_out({2'h0, amplitude_scale_out}, 8'h04);
         rd(LTC_ADDR_TRANSMIT_CONFIG_ZERO, 8'(t));
      end
      foreach (spots[k]) begin
         wr(LTC_ADDR_TRANSMIT_CONFIG_ZERO, {4'h0, spots[k][19:16]});
         wave_idx_in <= spots[k][13:8];
         settle(3);
         cmp_out({1'b0, wave_code_out}, spots[k][7:0]);
      end
      repeat (8) begin
         @(posedge clock_in);
         wave_idx_in <= 6'($random(seed));
         settle(2);
         cmp_out({1'b0, wave_code_out}, LTC_WAVE_D225[wave_idx_in]);
      end
      wr(LTC_ADDR_TRANSMIT_CONFIG_ZERO, 8'h00);
      settle(3);
      cmp_out({1'b0, wave_code_out}, 8'h00);
      wr(LTC_ADDR_SCALE, 8'h12);
      rd(LTC_ADDR_SCALE, 8'h12);
      wr(LTC_ADDR_TRANSMIT_CONFIG_ZERO, 8'h10);
      settle(3);
      cmp_out(tx_power_down_out, 8'h01);
      cmp_out(tx_line_oe_out, 8'h00);
      wr(LTC_ADDR_TRANSMIT_CONFIG_ZERO, 8'h00);
      wr(LTC_ADDR_CTL, 8'h01);
      settle(2);
      cmp_out(tx_line_oe_out, 8'h00);
      settle(6);
      rd(LTC_ADDR_SCALE, 8'h36);
      cmp_out(tx_line_oe_out, 8'h01);
      do_reset(1'b1);
      rd(LTC_ADDR_STAT, 8'h09);
      foreach (hwc[k]) begin
         @(posedge clock_in);
         pulse_template_sel_in <= hwc[k][7:4];
         settle(5);
         cmp_out({5'h0, tx_term_out}, {6'h0, hwc[k][1:0]});
         cmp_out({5'h0, rx_term_out}, {6'h0, hwc[k][1:0]});
         cmp_out({4'h0, pulse_template_sel_out}, {4'h0, hwc[k][7:4]});
      end
      @(posedge clock_in);
      term_strap_in <= 1'b0;
      settle(5);
      cmp_out({7'h0, tx_term_out.ext & rx_term_out.ext}, 8'h01);
      @(posedge clock_in);
      tx_float_ctl_in <= 1'b1;
      pattern_strap_hi_in <= 1'b1;
      settle(5);
      cmp_out(tx_line_oe_out, 8'h00);
      cmp_out(tx_power_down_out, 8'h00);
      @(posedge clock_in);
      tx_float_ctl_in <= 1'b0;
      pattern_strap_lo_in <= 1'b1;
      settle(5);
      cmp_out(tx_power_down_out, 8'h01);
      cmp_out(tx_line_oe_out, 8'h00);
      settle(4);
      test_done();
   end
endmodule
